// ---- rtl/gfpds_pkg.sv ----
// Constants, types and header check functions for the frame delineation block.
// How it works
// - Type flag bit set means the last four payload octets are a CRC-32 check.
// - Search tests every octet's last four octets; a header match enters tentative lock.
// - Tentative lock follows length fields and locks after a set count of good headers.
// - One bad header check in tentative lock returns to search at once.
// - Locked: multi-bit header error drops to search and raises server failure.
// - Idle frames are tracked like client frames, then dropped.
// - The confirmation count defaults to one.
// - Parallel trackers are optional; a single tracker is used here.
// - Payload descrambling uses self-synchronous x^43 + 1, most significant bit first.
// - Scrambling covers from after the header check to the frame's last octet.
// - Descrambler state is held while disabled, carrying across frames.
// - Descrambler is off in search and tentative lock.
// - Locked: descrambler runs only over the current frame's payload octets.
// - Length field counts payload octets; the next header follows them.
// - Lengths zero to three are control frames; client frames carry at least four.
// - The header check is a CRC-16 over the length field.
package gfpds_pkg;

   typedef enum logic [2:0] {
      search_state         = 3'h1,
      tentative_lock_state = 3'h2,
      locked_state         = 3'h4
   } gfpds_state_t;

   localparam int          SCR_LEN        = 43;
   localparam logic [15:0] HEC_POLY       = 16'h1021;
   localparam logic [15:0] HEC_INIT       = 16'h0000;
   localparam logic [1:0]  HDR_LAST       = 2'h3;
   localparam logic [15:0] MIN_CLIENT_LEN = 16'h0004;
   localparam logic [15:0] FCS_OCTETS     = 16'h0004;
   localparam logic [15:0] LAST_OCTET     = 16'h0001;
   localparam int          CHECK_FLAG_BIT = 4;
   localparam logic [3:0]  DELTA_DEFAULT  = 4'h1;

   localparam logic [7:0]  ADDR_CTRL      = 8'h00;
   localparam logic [7:0]  ADDR_STATUS    = 8'h04;
   localparam logic [7:0]  ADDR_INT_STAT  = 8'h08;
   localparam logic [7:0]  ADDR_INT_MASK  = 8'h0C;
   localparam logic [7:0]  ADDR_FRAMES    = 8'h10;
   localparam int          CTRL_CLR_BIT   = 8;
   localparam int          INT_LOFD       = 0;
   localparam int          INT_LOCK       = 1;
   localparam int          INT_CORR       = 2;
   localparam int          INT_W          = 3;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // Remainder of the length and check word; zero means a clean header.
   function automatic logic [15:0] hec_syndrome(input logic [31:0] w);
      logic [15:0] c;
      logic        fb;
      c = HEC_INIT;
      for (int i = 31; i >= 0; i--) begin
         fb = c[15] ^ w[i];
         c  = {c[14:0], 1'b0} ^ (fb ? HEC_POLY : 16'h0000);
      end
      return c;
   endfunction

   // Bit to flip for a single-bit error; all zero when the syndrome is not one.
   function automatic logic [31:0] hec_error_mask(input logic [15:0] syn);
      logic [31:0] m;
      m = 32'h0;
      for (int i = 0; i < 32; i++) begin
         if (syn != 16'h0000 && hec_syndrome(32'h1 << i) == syn) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

endpackage

// ---- rtl/gfpds_descrambler.sv ----
// Self-synchronous x^43 + 1 payload descrambler, one octet per enabled cycle.
`timescale 1ns/100ps
`default_nettype none
module gfpds_descrambler #(
   parameter int LEN = gfpds_pkg::SCR_LEN
) (
   input  wire logic       sys_clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       clear_i,
   input  wire logic       enable_i,
   input  wire logic [7:0] data_i,
   output logic      [7:0] data_o
);

   logic [LEN-1:0] shreg;
   logic [LEN-1:0] next_shreg;
   logic [LEN-1:0] walk;

   // Bits go through MSB first and the history is fed by received bits.
   always_comb begin
      walk = shreg;
      for (int i = 7; i >= 0; i--) begin
         data_o[i] = data_i[i] ^ walk[LEN-1];
         walk      = {walk[LEN-2:0], data_i[i]};
      end
      if (clear_i) begin
         next_shreg = '0;
      end else if (enable_i) begin
         next_shreg = walk;
      end else begin
         next_shreg = shreg;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         shreg <= '0;
      end else begin
         shreg <= next_shreg;
      end
   end

   a_hold_disabled: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      !enable_i && !clear_i |=> $stable(shreg))
      else $error("descrambler state moved while disabled");

endmodule
`default_nettype wire

// ---- rtl/gfpds_framer.sv ----
// Frame delineation, payload descrambling and AXI4-Lite control for the receive octet stream.
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module gfpds_framer #(
   parameter int ADDR_W = 8
) (
   input  wire logic              sys_clk_i,
   input  wire logic              reset_n_i,
   input  wire logic [7:0]        rx_data_i,
   input  wire logic              rx_valid_i,
   output var  logic [7:0]        cl_data_o,
   output var  logic              cl_valid_o,
   output var  logic              cl_start_o,
   output var  logic              cl_fcs_o,
   output var  logic              cl_fcs_present_o,
   output var  logic              server_failure_indication_o,
   output var  logic              irq_o,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input  wire logic              s_axi_awvalid_i,
   output var  logic              s_axi_awready_o,
   input  wire logic [31:0]       s_axi_wdata_i,
   input  wire logic [3:0]        s_axi_wstrb_i,
   input  wire logic              s_axi_wvalid_i,
   output var  logic              s_axi_wready_o,
   output var  logic [1:0]        s_axi_bresp_o,
   output var  logic              s_axi_bvalid_o,
   input  wire logic              s_axi_bready_i,
   input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input  wire logic              s_axi_arvalid_i,
   output var  logic              s_axi_arready_o,
   output var  logic [31:0]       s_axi_rdata_o,
   output var  logic [1:0]        s_axi_rresp_o,
   output var  logic              s_axi_rvalid_o,
   input  wire logic              s_axi_rready_i
);

   gfpds_pkg::gfpds_state_t state, next_state;
   logic [3:0]  conf_cnt, next_conf_cnt;
   logic        in_pay, next_in_pay;
   logic [1:0]  hdr_cnt, next_hdr_cnt;
   logic [15:0] remain, next_remain;
   logic        first, next_first;
   logic        client_frm, next_client_frm;
   logic        fcs_pres, next_fcs_pres;
   logic [23:0] hdr_sh, next_hdr_sh;
   logic [7:0]  next_cl_data;
   logic        next_cl_valid, next_cl_start, next_cl_fcs, next_cl_fcs_present;
   logic [31:0] win, emask;
   logic [15:0] syn, load_len;
   logic        hdr_chk, load_frame, fcs_eff, desc_en;
   logic        ev_lofd, ev_lock, ev_corr;
   logic [7:0]  desc_data;

   logic [3:0]  delta, next_delta;
   logic        sw_clr, next_sw_clr;
   logic [gfpds_pkg::INT_W-1:0] int_stat, next_int_stat, int_mask, next_int_mask, ev_vec;
   logic [31:0] frames, next_frames;
   logic        aw_have, next_aw_have, w_have, next_w_have;
   logic [ADDR_W-1:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0]  w_strb, next_w_strb;
   logic        next_bvalid, next_rvalid, next_arready, next_irq;
   logic [1:0]  next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic [7:0]  wr_addr, rd_addr;

   assign win     = {hdr_sh, rx_data_i};
   assign syn     = gfpds_pkg::hec_syndrome(win);
   assign emask   = gfpds_pkg::hec_error_mask(syn);
   assign desc_en = rx_valid_i && !sw_clr && in_pay
                    && state == gfpds_pkg::locked_state;

   gfpds_descrambler #(
      .LEN (gfpds_pkg::SCR_LEN)
   ) u_desc (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .clear_i   (sw_clr),
      .enable_i  (desc_en),
      .data_i    (rx_data_i),
      .data_o    (desc_data)
   );

   // One tracker only: a second candidate found while tracking is not followed.
   always_comb begin
      next_state          = state;
      next_conf_cnt       = conf_cnt;
      next_in_pay         = in_pay;
      next_hdr_cnt        = hdr_cnt;
      next_remain         = remain;
      next_first          = first;
      next_client_frm     = client_frm;
      next_fcs_pres       = fcs_pres;
      next_hdr_sh         = hdr_sh;
      next_cl_data        = cl_data_o;
      next_cl_valid       = 1'b0;
      next_cl_start       = 1'b0;
      next_cl_fcs         = 1'b0;
      next_cl_fcs_present = cl_fcs_present_o;
      ev_lofd             = 1'b0;
      ev_lock             = 1'b0;
      ev_corr             = 1'b0;
      hdr_chk             = 1'b0;
      load_frame          = 1'b0;
      load_len            = win[31:16];
      fcs_eff             = first ? desc_data[gfpds_pkg::CHECK_FLAG_BIT] : fcs_pres;
      if (sw_clr) begin
         next_state  = gfpds_pkg::search_state;
         next_conf_cnt = '0;
         next_in_pay = 1'b0;
         next_hdr_cnt = '0;
         next_remain = '0;
         next_hdr_sh = '0;
      end else if (rx_valid_i) begin
         next_hdr_sh = win[23:0];
         if (state == gfpds_pkg::search_state) begin
            if (syn == gfpds_pkg::HEC_INIT) begin
               next_state    = gfpds_pkg::tentative_lock_state;
               next_conf_cnt = '0;
               load_frame    = 1'b1;
            end
         end else if (in_pay) begin
            if (first) begin
               next_fcs_pres = desc_data[gfpds_pkg::CHECK_FLAG_BIT];
            end
            if (state == gfpds_pkg::locked_state && client_frm) begin
               next_cl_valid = 1'b1;
               next_cl_data  = desc_data;
               next_cl_start = first;
               next_cl_fcs   = fcs_eff && remain <= gfpds_pkg::FCS_OCTETS;
               if (first) begin
                  next_cl_fcs_present = desc_data[gfpds_pkg::CHECK_FLAG_BIT];
               end
            end
            next_first  = 1'b0;
            next_remain = remain - gfpds_pkg::LAST_OCTET;
            if (remain == gfpds_pkg::LAST_OCTET) begin
               next_in_pay  = 1'b0;
               next_hdr_cnt = '0;
            end
         end else if (hdr_cnt != gfpds_pkg::HDR_LAST) begin
            next_hdr_cnt = hdr_cnt + 2'h1;
         end else begin
            hdr_chk = 1'b1;
            if (state == gfpds_pkg::tentative_lock_state) begin
               if (syn == gfpds_pkg::HEC_INIT) begin
                  load_frame = 1'b1;
                  if (({1'b0, conf_cnt} + 5'h01) >= {1'b0, delta}) begin
                     next_state = gfpds_pkg::locked_state;
                     ev_lock    = 1'b1;
                  end else begin
                     next_conf_cnt = conf_cnt + 4'h1;
                  end
               end else begin
                  next_state = gfpds_pkg::search_state;
               end
            end else if (syn == gfpds_pkg::HEC_INIT) begin
               load_frame = 1'b1;
            end else if (emask != 32'h0) begin
               load_frame = 1'b1;
               load_len   = win[31:16] ^ emask[31:16];
               ev_corr    = 1'b1;
            end else begin
               next_state = gfpds_pkg::search_state;
               ev_lofd    = 1'b1;
            end
         end
         if (load_frame) begin
            next_remain     = load_len;
            next_in_pay     = load_len != 16'h0000;
            next_hdr_cnt    = '0;
            next_first      = 1'b1;
            next_client_frm = load_len >= gfpds_pkg::MIN_CLIENT_LEN;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state            <= gfpds_pkg::search_state;
         conf_cnt         <= '0;
         in_pay           <= 1'b0;
         hdr_cnt          <= '0;
         remain           <= '0;
         first            <= 1'b0;
         client_frm       <= 1'b0;
         fcs_pres         <= 1'b0;
         hdr_sh           <= '0;
         cl_data_o        <= '0;
         cl_valid_o       <= 1'b0;
         cl_start_o       <= 1'b0;
         cl_fcs_o         <= 1'b0;
         cl_fcs_present_o <= 1'b0;
         server_failure_indication_o <= 1'b1;
      end else begin
         state            <= next_state;
         conf_cnt         <= next_conf_cnt;
         in_pay           <= next_in_pay;
         hdr_cnt          <= next_hdr_cnt;
         remain           <= next_remain;
         first            <= next_first;
         client_frm       <= next_client_frm;
         fcs_pres         <= next_fcs_pres;
         hdr_sh           <= next_hdr_sh;
         cl_data_o        <= next_cl_data;
         cl_valid_o       <= next_cl_valid;
         cl_start_o       <= next_cl_start;
         cl_fcs_o         <= next_cl_fcs;
         cl_fcs_present_o <= next_cl_fcs_present;
         server_failure_indication_o <= next_state != gfpds_pkg::locked_state;
      end
   end

   // A write completes only once both address and data are held, in either order.
   always_comb begin
      next_aw_have  = aw_have;
      next_w_have   = w_have;
      next_aw_addr  = aw_addr;
      next_w_data   = w_data;
      next_w_strb   = w_strb;
      next_bvalid   = s_axi_bvalid_o;
      next_bresp    = s_axi_bresp_o;
      next_rvalid   = s_axi_rvalid_o;
      next_rresp    = s_axi_rresp_o;
      next_rdata    = s_axi_rdata_o;
      next_delta    = delta;
      next_sw_clr   = 1'b0;
      next_int_mask = int_mask;
      ev_vec        = '0;
      ev_vec[gfpds_pkg::INT_LOFD] = ev_lofd;
      ev_vec[gfpds_pkg::INT_LOCK] = ev_lock;
      ev_vec[gfpds_pkg::INT_CORR] = ev_corr;
      next_int_stat = int_stat;
      next_frames   = frames + {31'h0, next_cl_start};
      wr_addr       = 8'(aw_addr);
      rd_addr       = 8'(s_axi_araddr_i);
      if (s_axi_awvalid_i && s_axi_awready_o) begin
         next_aw_have = 1'b1;
         next_aw_addr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
         next_w_have = 1'b1;
         next_w_data = s_axi_wdata_i;
         next_w_strb = s_axi_wstrb_i;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
         next_bvalid = 1'b0;
      end
      if (aw_have && w_have && !s_axi_bvalid_o) begin
         next_aw_have = 1'b0;
         next_w_have  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = gfpds_pkg::RESP_OKAY;
         if (wr_addr == gfpds_pkg::ADDR_CTRL) begin
            if (w_strb[0]) begin
               next_delta = w_data[3:0];
            end
            if (w_strb[1]) begin
               next_sw_clr = w_data[gfpds_pkg::CTRL_CLR_BIT];
            end
         end else if (wr_addr == gfpds_pkg::ADDR_INT_STAT) begin
            if (w_strb[0]) begin
               next_int_stat = int_stat & ~w_data[gfpds_pkg::INT_W-1:0];
            end
         end else if (wr_addr == gfpds_pkg::ADDR_INT_MASK) begin
            if (w_strb[0]) begin
               next_int_mask = w_data[gfpds_pkg::INT_W-1:0];
            end
         end else if (wr_addr != gfpds_pkg::ADDR_STATUS && wr_addr != gfpds_pkg::ADDR_FRAMES) begin
            next_bresp = gfpds_pkg::RESP_SLVERR;
         end
      end
      // An event in the clearing cycle survives the clear.
      next_int_stat = next_int_stat | ev_vec;
      if (s_axi_rvalid_o && s_axi_rready_i) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid_i && s_axi_arready_o) begin
         next_rvalid = 1'b1;
         next_rresp  = gfpds_pkg::RESP_OKAY;
         next_rdata  = 32'h0;
         if (rd_addr == gfpds_pkg::ADDR_CTRL) begin
            next_rdata[3:0] = delta;
         end else if (rd_addr == gfpds_pkg::ADDR_STATUS) begin
            next_rdata[3:0] = {server_failure_indication_o, state};
         end else if (rd_addr == gfpds_pkg::ADDR_INT_STAT) begin
            next_rdata[gfpds_pkg::INT_W-1:0] = int_stat;
         end else if (rd_addr == gfpds_pkg::ADDR_INT_MASK) begin
            next_rdata[gfpds_pkg::INT_W-1:0] = int_mask;
         end else if (rd_addr == gfpds_pkg::ADDR_FRAMES) begin
            next_rdata = frames;
         end else begin
            next_rresp = gfpds_pkg::RESP_SLVERR;
         end
      end
      next_arready = !next_rvalid;
      next_irq     = |(next_int_stat & next_int_mask);
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         aw_have         <= 1'b0;
         w_have          <= 1'b0;
         aw_addr         <= '0;
         w_data          <= '0;
         w_strb          <= '0;
         delta           <= gfpds_pkg::DELTA_DEFAULT;
         sw_clr          <= 1'b0;
         int_stat        <= '0;
         int_mask        <= '0;
         frames          <= '0;
         irq_o           <= 1'b0;
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o  <= 1'b0;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= gfpds_pkg::RESP_OKAY;
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rresp_o   <= gfpds_pkg::RESP_OKAY;
         s_axi_rdata_o   <= '0;
      end else begin
         aw_have         <= next_aw_have;
         w_have          <= next_w_have;
         aw_addr         <= next_aw_addr;
         w_data          <= next_w_data;
         w_strb          <= next_w_strb;
         delta           <= next_delta;
         sw_clr          <= next_sw_clr;
         int_stat        <= next_int_stat;
         int_mask        <= next_int_mask;
         frames          <= next_frames;
         irq_o           <= next_irq;
         s_axi_awready_o <= !next_aw_have;
         s_axi_wready_o  <= !next_w_have;
         s_axi_bvalid_o  <= next_bvalid;
         s_axi_bresp_o   <= next_bresp;
         s_axi_arready_o <= next_arready;
         s_axi_rvalid_o  <= next_rvalid;
         s_axi_rresp_o   <= next_rresp;
         s_axi_rdata_o   <= next_rdata;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);

   a_search_match: assert property (
      state == gfpds_pkg::search_state && rx_valid_i && !sw_clr && syn == 16'h0000
      |=> state == gfpds_pkg::tentative_lock_state)
      else $error("clean candidate header did not start tentative lock");
   a_tent_fail: assert property (
      state == gfpds_pkg::tentative_lock_state && hdr_chk && syn != 16'h0000
      |=> state == gfpds_pkg::search_state)
      else $error("bad header in tentative lock did not return to search");
   a_tent_confirm: assert property (
      state == gfpds_pkg::tentative_lock_state && hdr_chk && syn == 16'h0000
      && delta == 4'h1 |=> state == gfpds_pkg::locked_state
      ##1 !server_failure_indication_o)
      else $error("confirmed header did not lock");
   a_lock_loss: assert property (
      state == gfpds_pkg::locked_state && hdr_chk && syn != 16'h0000 && emask == 32'h0
      |=> state == gfpds_pkg::search_state && int_stat[gfpds_pkg::INT_LOFD]
      ##1 server_failure_indication_o)
      else $error("multi-bit header error did not drop lock");
   a_single_fix: assert property (
      state == gfpds_pkg::locked_state && hdr_chk && emask != 32'h0
      |=> state == gfpds_pkg::locked_state
      && remain == ($past(win[31:16]) ^ $past(emask[31:16])))
      else $error("single-bit header error not corrected");
   a_desc_gate: assert property (
      state != gfpds_pkg::locked_state |-> !desc_en)
      else $error("descrambler enabled outside lock");
   a_idle_drop: assert property (
      in_pay && rx_valid_i && !client_frm |=> !cl_valid_o)
      else $error("control frame octet passed to client");
   a_frame_end: assert property (
      in_pay && rx_valid_i && !sw_clr && remain == 16'h0001 |=> !in_pay && hdr_cnt == 2'h0)
      else $error("frame boundary misplaced");
   a_fcs_mark: assert property (
      cl_valid_o && cl_fcs_o |-> cl_fcs_present_o)
      else $error("check octet flagged without payload check present");
   a_irq_level: assert property (
      |(int_stat & int_mask) |-> irq_o)
      else $error("interrupt low with unmasked status set");

   c_lock: cover property (state == gfpds_pkg::tentative_lock_state ##1
                           state == gfpds_pkg::locked_state);
   c_loss: cover property (ev_lofd);
   c_corr: cover property (ev_corr);
   c_idle: cover property (state == gfpds_pkg::locked_state && hdr_chk && load_len == 16'h0000);

endmodule
`default_nettype wire

// ---- tb/gfpds_link_src.sv ----
// Transmit-side model of the link: frames octets and scrambles payloads.
`timescale 1ns/100ps
`default_nettype none
module gfpds_link_src (
   input  wire logic       sys_clk_i,
   output logic      [7:0] rx_data_o,
   output logic            rx_valid_o
);
   logic [42:0] hist = 43'h0;
   initial begin
      rx_data_o  = 8'h00;
      rx_valid_o = 1'h0;
   end
   function automatic logic [15:0] crc16(input logic [15:0] d);
      logic [15:0] c;
      c = 16'h0000;
      for (int i = 15; i >= 0; i--) begin
         c = {c[14:0], 1'h0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
      end
      return c;
   endfunction
   task automatic put(input logic [7:0] b);
      @(posedge sys_clk_i);
      rx_data_o  <= b;
      rx_valid_o <= 1'h1;
   endtask
   // Released data flips so a stale octet is never mistaken for a fresh one.
   task automatic pause();
      @(posedge sys_clk_i);
      rx_valid_o <= 1'h0;
      rx_data_o  <= ~rx_data_o;
   endtask
   // Payload octet n is n, except the first; err corrupts the header check.
   task automatic frame(input logic [15:0] len, input logic [7:0] first, input logic [15:0] err);
      logic [31:0] w;
      logic [7:0]  s;
      w = {len, crc16(len) ^ err};
      for (int k = 3; k >= 0; k--) begin
         put(w[k*8+:8]);
      end
      for (int n = 0; n < len; n++) begin
         for (int i = 7; i >= 0; i--) begin
            s[i] = ((n == 0) ? first[i] : n[i]) ^ hist[42];
            hist = {hist[41:0], s[i]};
         end
         put(s);
      end
   endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Bench for the frame delineation block: octet stream, client side and registers.
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        sys_clk_i = 1'h0;
   logic        reset_n_i = 1'h0;
   logic [7:0]  rx_data, cl_data, awaddr = 8'h00, araddr = 8'h00;
   logic        rx_valid, cl_valid, cl_start, cl_fcs, fcs_pres, srv_fail, irq;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0]  wstrb = 4'h0;
   logic [1:0]  bresp, rresp;
   logic [7:0]  got_q[$];
   int          failures = 0, n_compared = 0, n_start = 0, n_fcs = 0;
   gfpds_link_src u_src (.sys_clk_i, .rx_data_o(rx_data), .rx_valid_o(rx_valid));
   gfpds_framer u_dut (.sys_clk_i, .reset_n_i, .rx_data_i(rx_data), .rx_valid_i(rx_valid),
      .cl_data_o(cl_data), .cl_valid_o(cl_valid), .cl_start_o(cl_start), .cl_fcs_o(cl_fcs),
      .cl_fcs_present_o(fcs_pres), .server_failure_indication_o(srv_fail), .irq_o(irq),
      .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready));
   initial forever #2.5 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) begin
      if (cl_valid === 1'h1) got_q.push_back(cl_data);
      if (cl_start === 1'h1) n_start++;
      if (cl_fcs === 1'h1) n_fcs++;
   end
   task automatic conclude();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stall();
      failures++;
      $display("wrong value at %0t: bus answer never came", $time);
      conclude();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int t;
      @(posedge sys_clk_i);
      {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, s, 3'h7};
      t = 0;
      do begin
         @(posedge sys_clk_i);
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
         t++;
      end while (bvalid !== 1'h1 && t < 50);
      bready <= 1'h0;
      if (bvalid !== 1'h1) stall();
      check({30'h0, bresp}, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      int t;
      @(posedge sys_clk_i);
      {araddr, arvalid, rready} <= {a, 2'h3};
      t = 0;
      do begin
         @(posedge sys_clk_i);
         if (arready === 1'h1) arvalid <= 1'h0;
         t++;
      end while (rvalid !== 1'h1 && t < 50);
      rready <= 1'h0;
      if (rvalid !== 1'h1) stall();
      check(rdata, exp);
      check({30'h0, rresp}, {30'h0, er});
   endtask
   // A long first frame keeps the search from matching the all-zero history.
   task automatic lock();
      u_src.frame(16'h0108, 8'h00, 16'h0000);
      u_src.frame(16'h0008, 8'h00, 16'h0000);
      u_src.frame(16'h0000, 8'h00, 16'h0000);
      u_src.pause();
   endtask
   initial begin
      repeat (3) @(posedge sys_clk_i);
      reset_n_i <= 1'h1;
      rd(8'h04, 32'h9, 2'h0);
      rd(8'h20, 32'h0, 2'h2);
      wr(8'h0C, 32'h7, 4'h1);
      u_src.frame(16'h0108, 8'h00, 16'h0000);
      u_src.pause();
      rd(8'h04, 32'hA, 2'h0);
      u_src.frame(16'h0006, 8'h00, 16'h0001);
      u_src.pause();
      rd(8'h04, 32'h9, 2'h0);
      lock();
      rd(8'h04, 32'h4, 2'h0);
      got_q.delete();
      n_start = 0;
      n_fcs = 0;
      u_src.frame(16'h0008, 8'h10, 16'h0000);
      // A two-octet control frame is tracked and descrambled but never reaches the client.
      u_src.frame(16'h0002, 8'h00, 16'h0000);
      u_src.frame(16'h0000, 8'h00, 16'h0000);
      u_src.pause();
      rd(8'h08, 32'h2, 2'h0);
      check({31'h0, irq}, 32'h1);
      check(got_q.size(), 32'h8);
      foreach (got_q[i]) check({24'h0, got_q[i]}, (i == 0) ? 32'h10 : i);
      check(n_start, 32'h1);
      check(n_fcs, 32'h4);
      check({31'h0, fcs_pres}, 32'h1);
      wr(8'h08, 32'h7, 4'h1);
      rd(8'h08, 32'h0, 2'h0);
      check({31'h0, irq}, 32'h0);
      u_src.frame(16'h0004, 8'h00, 16'h0001);
      u_src.pause();
      rd(8'h04, 32'h4, 2'h0);
      rd(8'h08, 32'h4, 2'h0);
      rd(8'h10, 32'h3, 2'h0);
      u_src.frame(16'h0004, 8'h00, 16'h0003);
      u_src.pause();
      rd(8'h04, 32'h9, 2'h0);
      rd(8'h08, 32'h5, 2'h0);
      check({31'h0, srv_fail}, 32'h1);
      // With two confirmations the eight-octet frame is still tentative, so it is not counted.
      wr(8'h00, 32'h2, 4'h1);
      lock();
      rd(8'h04, 32'h4, 2'h0);
      wr(8'h00, 32'h100, 4'h2);
      rd(8'h04, 32'h9, 2'h0);
      rd(8'h10, 32'h3, 2'h0);
      rd(8'h00, 32'h2, 2'h0);
      conclude();
   end
endmodule
`default_nettype wire
